// file: src/sdp_top.sv
// parallel word side of the serdes: encode, serialize, align, decode
`timescale 1ns/1ns
`include "sdp_consts.svh"
module sdp_top (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic          [4:0]  avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic          [31:0] avs_writedata,
  output logic               [31:0] avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      irq,
  input  wire logic                 reference_word_clock,
  input  wire sdp_pkg::sdp_tx_word_t tx_word,
  output logic                      tx_serial,
  output logic                      tx_bit_clock,
  input  wire logic                 rx_serial,
  input  wire logic                 signal_absent,
  input  wire logic                 pattern_test_enable,
  input  wire logic                 factory_test_enable,
  output logic                      rx_word_clock,
  output logic               [15:0] rx_data,
  output logic                      rx_kcode_low_flag,
  output logic                      rx_kcode_high_flag,
  output logic                      pattern_check_ok
);
  import sdp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic          ack_reg;
  logic          ack_next;
  logic          take;
  logic [31:0]   rdata_next;
  logic [1:0]    ctrl_reg;
  logic [1:0]    ctrl_next;
  logic [3:0]    mask_reg;
  logic [3:0]    mask_next;
  logic [3:0]    istat_reg;
  logic [3:0]    istat_next;
  logic [3:0]    events;
  logic          pattern_mode;

  logic          ref_prev_reg;
  logic          rise;
  sdp_tx_word_t  cap_reg;
  sdp_tx_word_t  cap_next;
  logic          cap_load_reg;
  logic [4:0]    tx_cnt_reg;
  logic [4:0]    tx_cnt_next;
  logic [19:0]   hold_reg;
  logic [19:0]   hold_next;
  logic [19:0]   shift_reg;
  logic [19:0]   shift_next;
  logic [9:0]    code_lo;
  logic [9:0]    code_hi;
  logic [6:0]    prbs_reg;
  logic [6:0]    prbs_next;
  logic          tx_serial_next;

  logic [19:0]   rx_sh_reg;
  logic [19:0]   rx_sh_next;
  logic [4:0]    rx_cnt_reg;
  logic [4:0]    rx_cnt_next;
  sdp_rx_state_t rx_state_reg;
  sdp_rx_state_t rx_state_next;
  sdp_rx_byte_t  dec_lo;
  sdp_rx_byte_t  dec_hi;
  logic          err_lo;
  logic          err_hi;
  sdp_rx_byte_t  pend_lo_reg;
  sdp_rx_byte_t  pend_lo_next;
  sdp_rx_byte_t  pend_hi_reg;
  sdp_rx_byte_t  pend_hi_next;
  logic          rx_klo_reg;
  logic          rx_klo_next;
  logic [15:0]   rx_data_next;
  logic          rx_khi_next;
  logic          rx_clk_next;
  logic          klo_pin_next;
  logic          comma_hit;
  logic          done;
  logic          absent_prev_reg;
  logic [6:0]    hist_reg;
  logic [6:0]    hist_next;
  logic          miss;
  logic          fail_reg;
  logic          fail_next;
  logic          pat_ok_next;

  ////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, then the access is taken
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign take            = (avs_read | avs_write) & ack_reg;
  assign pattern_mode    = pattern_test_enable | ctrl_reg[`SDP_CTRL_PATTERN];
  assign irq             = |(istat_reg & mask_reg);

  // read data is sampled one cycle early so it stands at the take edge
  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = avs_readdata;
    ctrl_next  = ctrl_reg;
    mask_next  = mask_reg;
    if (ack_next && avs_read) begin
      case (avs_address)
        `SDP_REG_CTRL:     rdata_next = {30'h0, ctrl_reg};
        `SDP_REG_STATUS:   rdata_next = {28'h0, factory_test_enable,
                                         pattern_check_ok, signal_absent,
                                         rx_state_reg == SDP_LOCK};
        `SDP_REG_IRQ_STAT: rdata_next = {28'h0, istat_reg};
        `SDP_REG_IRQ_MASK: rdata_next = {28'h0, mask_reg};
        `SDP_REG_RX_WORD:  rdata_next = {14'h0, rx_kcode_high_flag,
                                         rx_klo_reg, rx_data};
        default:           rdata_next = 32'h0; // unmapped reads zero
      endcase
    end
    if (take && avs_write && avs_address == `SDP_REG_CTRL) begin
      ctrl_next = avs_writedata[1:0];
    end
    if (take && avs_write && avs_address == `SDP_REG_IRQ_MASK) begin
      mask_next = avs_writedata[3:0];
    end
  end

  // bus registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl_reg     <= `SDP_CTRL_RESET;
      mask_reg     <= 4'h0;
    end else begin
      ack_reg      <= ack_next;
      avs_readdata <= rdata_next;
      ctrl_reg     <= ctrl_next;
      mask_reg     <= mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: read clears only what the read returned, so an
  // event landing in the same cycle is kept
  always_comb begin
    istat_next = istat_reg;
    if (take && avs_read && avs_address == `SDP_REG_IRQ_STAT) begin
      istat_next = istat_reg & ~avs_readdata[3:0];
    end
    istat_next = istat_next | events;
  end

  // interrupt register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      istat_reg <= 4'h0;
    end else begin
      istat_reg <= istat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit: capture, two encoders, hold, serializer
  sdp_enc u_enc_lo (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (cap_load_reg),
    .byte_in (cap_reg.data[7:0]),
    .k_in    (cap_reg.k_lo),
    .code    (code_lo)
  );

  sdp_enc u_enc_hi (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (cap_load_reg),
    .byte_in (cap_reg.data[15:8]),
    .k_in    (cap_reg.k_hi),
    .code    (code_hi)
  );

  assign rise = reference_word_clock & ~ref_prev_reg;

  // the word is held one period so the serializer slot is fixed; bit 0
  // leaves 37 cycles after the capturing edge
  always_comb begin
    cap_next    = rise ? tx_word : cap_reg;
    tx_cnt_next = (rise || tx_cnt_reg == `SDP_LAST_BIT) ? 5'h00
                  : tx_cnt_reg + 5'h01;
    hold_next   = (tx_cnt_reg == `SDP_LAST_BIT) ? {code_hi, code_lo}
                  : hold_reg;
    shift_next  = (tx_cnt_reg == `SDP_TX_LOAD_SLOT) ? hold_reg
                  : {1'b0, shift_reg[19:1]};
    prbs_next   = {prbs_reg[5:0], prbs_reg[6] ^ prbs_reg[5]};
    tx_serial_next = ctrl_reg[`SDP_CTRL_TX_EN] &
                     (pattern_mode ? prbs_reg[6] : shift_reg[0]);
  end

  // transmit registers; the bit clock toggles every cycle, one bit per
  // edge of it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_prev_reg <= 1'b0;
      cap_reg      <= '0;
      cap_load_reg <= 1'b0;
      tx_cnt_reg   <= 5'h00;
      hold_reg     <= 20'h0;
      shift_reg    <= 20'h0;
      prbs_reg     <= `SDP_PRBS_SEED;
      tx_serial    <= 1'b0;
      tx_bit_clock <= 1'b0;
    end else begin
      ref_prev_reg <= reference_word_clock;
      cap_reg      <= cap_next;
      cap_load_reg <= rise;
      tx_cnt_reg   <= tx_cnt_next;
      hold_reg     <= hold_next;
      shift_reg    <= shift_next;
      prbs_reg     <= prbs_next;
      tx_serial    <= tx_serial_next;
      tx_bit_clock <= ~tx_bit_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive: comma alignment, decode, word clock
  sdp_dec u_dec_lo (
    .code   (rx_sh_reg[9:0]),
    .result (dec_lo),
    .error  (err_lo)
  );

  sdp_dec u_dec_hi (
    .code   (rx_sh_reg[19:10]),
    .result (dec_hi),
    .error  (err_hi)
  );

  // a comma in the low symbol marks a whole word in the shifter
  assign comma_hit = rx_sh_reg[6:0] == `SDP_COMMA && !signal_absent;
  assign done      = comma_hit || rx_cnt_reg == `SDP_LAST_BIT;
  assign miss      = rx_serial != (hist_reg[6] ^ hist_reg[5]);

  // word, high flag and, outside pattern mode, low flag change on the falling word clock so they stand at the rise
  always_comb begin
    rx_sh_next    = {rx_serial, rx_sh_reg[19:1]};
    rx_cnt_next   = done ? 5'h00 : rx_cnt_reg + 5'h01;
    rx_clk_next   = rx_cnt_next < `SDP_HALF_BIT;
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      SDP_HUNT: if (comma_hit)     rx_state_next = SDP_LOCK;
      SDP_LOCK: if (signal_absent) rx_state_next = SDP_HUNT;
      default:  rx_state_next = SDP_HUNT;
    endcase
    pend_lo_next = pend_lo_reg;
    pend_hi_next = pend_hi_reg;
    if (done && signal_absent) begin
      pend_lo_next = '{data: `SDP_LOS_BYTE, k: 1'b1};
      pend_hi_next = '{data: `SDP_LOS_BYTE, k: 1'b1};
    end else if (done) begin
      pend_lo_next = dec_lo;
      pend_hi_next = dec_hi;
    end
    rx_data_next = rx_data;
    rx_klo_next  = rx_klo_reg;
    rx_khi_next  = rx_kcode_high_flag;
    if (rx_cnt_next == `SDP_HALF_BIT) begin
      rx_data_next = {pend_hi_reg.data, pend_lo_reg.data};
      rx_klo_next  = pend_lo_reg.k;
      rx_khi_next  = pend_hi_reg.k;
    end
    // pattern check: each bit must follow from the seven before it
    hist_next   = {hist_reg[5:0], rx_serial};
    fail_next   = done ? 1'b0 : (fail_reg | miss);
    pat_ok_next = done ? ~(fail_reg | miss) : pattern_check_ok;
    klo_pin_next = pattern_mode ? pattern_check_ok : rx_klo_next;
    events = 4'h0;
    events[`SDP_IRQ_DECODE]  = done & ~signal_absent & (err_lo | err_hi);
    events[`SDP_IRQ_LOS]     = signal_absent & ~absent_prev_reg;
    events[`SDP_IRQ_REALIGN] = comma_hit & rx_state_reg == SDP_LOCK &
                               rx_cnt_reg != `SDP_LAST_BIT;
    events[`SDP_IRQ_PATTERN] = pattern_mode & done & (fail_reg | miss);
  end

  // receive registers; the word clock is low through reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sh_reg          <= 20'h0;
      rx_cnt_reg         <= 5'h00;
      rx_state_reg       <= SDP_HUNT;
      rx_word_clock      <= 1'b0;
      pend_lo_reg        <= '0;
      pend_hi_reg        <= '0;
      rx_data            <= 16'h0;
      rx_klo_reg         <= 1'b0;
      rx_kcode_high_flag <= 1'b0;
      rx_kcode_low_flag  <= 1'b0;
      absent_prev_reg    <= 1'b0;
      hist_reg           <= 7'h00;
      fail_reg           <= 1'b0;
      pattern_check_ok   <= 1'b0;
    end else begin
      rx_sh_reg          <= rx_sh_next;
      rx_cnt_reg         <= rx_cnt_next;
      rx_state_reg       <= rx_state_next;
      rx_word_clock      <= rx_clk_next;
      pend_lo_reg        <= pend_lo_next;
      pend_hi_reg        <= pend_hi_next;
      rx_data            <= rx_data_next;
      rx_klo_reg         <= rx_klo_next;
      rx_kcode_high_flag <= rx_khi_next;
      rx_kcode_low_flag  <= klo_pin_next;
      absent_prev_reg    <= signal_absent;
      hist_reg           <= hist_next;
      fail_reg           <= fail_next;
      pattern_check_ok   <= pat_ok_next;
    end
  end
endmodule : sdp_top

// file: src/sdp_consts.svh
// named constants for the serdes parallel word interface
// Summary of operation
// - recovered word clock is serial rate over 20
// - recovered word clock held low during reset
// - receive word and flags timed by recovered clock
// - low flag marks low byte as K code
// - high flag marks high byte as K code
// - pattern mode turns low flag into check pass
// - transmit word captured on word clock rise
// - high control selects K code for high byte
// - low control selects K code for low byte
// - bit clock ten times word, both edges shift
// - serial word sent least significant bit first
// - transmit latency held within 34 to 38 bits
// - two independent byte encoders
// - bad byte shows as K0.0 on itself
// - lost signal shows K31.7 on both bytes
`ifndef SDP_CONSTS_SVH
`define SDP_CONSTS_SVH
`define SDP_LAST_BIT     5'h13
`define SDP_HALF_BIT     5'h0A
`define SDP_HALF_M1      5'h09
`define SDP_TX_LOAD_SLOT 5'h0F
`define SDP_COMMA        7'h7C
`define SDP_ERR_BYTE     8'h00
`define SDP_LOS_BYTE     8'hFF
`define SDP_PRBS_SEED    7'h7F
`define SDP_REG_CTRL     5'h00
`define SDP_REG_STATUS   5'h04
`define SDP_REG_IRQ_STAT 5'h08
`define SDP_REG_IRQ_MASK 5'h0C
`define SDP_REG_RX_WORD  5'h10
`define SDP_CTRL_RESET   2'h1
`define SDP_CTRL_TX_EN   0
`define SDP_CTRL_PATTERN 1
`define SDP_IRQ_DECODE   0
`define SDP_IRQ_LOS      1
`define SDP_IRQ_REALIGN  2
`define SDP_IRQ_PATTERN  3
`endif

// file: src/sdp_pkg.sv
// types and 8b/10b coding tables for the serdes parallel word interface
package sdp_pkg;
  typedef struct packed {
    logic [15:0] data;
    logic        k_hi;
    logic        k_lo;
  } sdp_tx_word_t;

  typedef struct packed {
    logic [7:0] data;
    logic       k;
  } sdp_rx_byte_t;

  typedef enum logic {SDP_HUNT, SDP_LOCK} sdp_rx_state_t;

  // 5b/6b codes for negative disparity, bit a in the msb
  localparam logic [5:0] SDP_T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  // 3b/4b codes for negative disparity, bit f in the msb
  localparam logic [3:0] SDP_T4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [5:0] SDP_K28_6B = 6'h0F;
  localparam logic [3:0] SDP_ALT7   = 4'h7;

  function automatic logic [3:0] sdp_ones(input logic [5:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : sdp_ones

  // returns {running disparity out, code}; code bit 0 is sent first
  function automatic logic [10:0] sdp_encode(input logic [7:0] b,
                                             input logic       k,
                                             input logic       rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] six;
    logic [3:0] four;
    logic       rd_mid;
    logic       flip4;
    logic [9:0] msb_first;
    logic [9:0] code;
    x = b[4:0];
    y = b[7:5];
    six = (k && x == 5'h1C) ? SDP_K28_6B : SDP_T6[x];
    rd_mid = (sdp_ones(six) != 4'h3) ? ~rd : rd;
    if (rd && (sdp_ones(six) != 4'h3 || (x == 5'h07 && !k))) begin
      six = ~six;
    end
    four = SDP_T4[y];
    if (y == 3'h7 && (k || (!rd_mid && (x == 5'h11 || x == 5'h12 ||
        x == 5'h14)) || (rd_mid && (x == 5'h0B || x == 5'h0D ||
        x == 5'h0E)))) begin
      four = SDP_ALT7;
    end
    flip4 = (sdp_ones({2'h0, four}) != 4'h2) || y == 3'h3;
    // comma symbols invert the balanced tails, all but y 3, after a negative head
    if (k && x == 5'h1C && !rd_mid) begin
      four = flip4 ? four : ~four;
    end else if (rd_mid && flip4) begin
      four = ~four;
    end
    msb_first = {six, four};
    for (int i = 0; i < 10; i++) begin
      code[i] = msb_first[9 - i];
    end
    return {(sdp_ones({2'h0, four}) != 4'h2) ? ~rd_mid : rd_mid, code};
  endfunction : sdp_encode
endpackage : sdp_pkg

// file: src/sdp_enc.sv
// one byte 8b/10b encoder with its own running disparity
`timescale 1ns/1ns
module sdp_enc (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       load,
  input  wire logic [7:0] byte_in,
  input  wire logic       k_in,
  output logic      [9:0] code
);
  import sdp_pkg::*;
  logic [9:0]  code_next;
  logic        rd_reg;
  logic        rd_next;
  logic [10:0] enc;

  // k control picks the K table, otherwise data coding
  always_comb begin
    enc       = sdp_encode(byte_in, k_in, rd_reg);
    code_next = load ? enc[9:0] : code;
    rd_next   = load ? enc[10] : rd_reg;
  end

  // disparity starts negative
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code   <= 10'h000;
      rd_reg <= 1'b0;
    end else begin
      code   <= code_next;
      rd_reg <= rd_next;
    end
  end
endmodule : sdp_enc

// file: src/sdp_dec.sv
// one byte 8b/10b decoder with error substitution
`timescale 1ns/1ns
`include "sdp_consts.svh"
module sdp_dec (
  input  wire logic         [9:0] code,
  output sdp_pkg::sdp_rx_byte_t   result,
  output logic                    error
);
  import sdp_pkg::*;
  logic [10:0] cand;
  logic [7:0]  b;
  logic        legal_k;
  logic        found;

  // search every byte and disparity; slow to build but exact
  always_comb begin
    cand    = 11'h000;
    b       = 8'h00;
    legal_k = 1'b0;
    found   = 1'b0;
    result  = '{data: `SDP_ERR_BYTE, k: 1'b1};
    for (int i = 0; i < 1024; i++) begin
      b       = i[7:0];
      legal_k = b[4:0] == 5'h1C || (b[7:5] == 3'h7 && (b[4:0] == 5'h17
                || b[4:0] == 5'h1B || b[4:0] == 5'h1D || b[4:0] == 5'h1E));
      cand    = sdp_encode(b, i[8], i[9]);
      if (!found && cand[9:0] == code && (!i[8] || legal_k)) begin
        found  = 1'b1;
        result = '{data: b, k: i[8]};
      end
    end
    error = ~found;
  end
endmodule : sdp_dec

// file: testbench/sdp_partner.sv
// protocol device model: word clock, transmit words, receive capture
`timescale 1ns/1ns
module sdp_partner (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire sdp_pkg::sdp_tx_word_t word_in,
  output logic                       reference_word_clock,
  output sdp_pkg::sdp_tx_word_t      tx_word,
  input  wire logic                  rx_word_clock,
  input  wire logic           [15:0] rx_data,
  input  wire logic                  rx_kcode_low_flag,
  input  wire logic                  rx_kcode_high_flag,
  output logic                [17:0] got
);
  import sdp_pkg::*;
  logic [4:0] cnt_reg;
  logic       rx_prev_reg;
  //////////////////////////////////////////////////////////////////////
  // word clock of 20 clk; the word changes on its fall so it is steady
  // over the rise, never at the sampling point
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg              <= 5'h00;
      reference_word_clock <= 1'b0;
      tx_word              <= '0;
    end else begin
      cnt_reg              <= (cnt_reg == 5'h13) ? 5'h00 : cnt_reg + 5'h01;
      reference_word_clock <= (cnt_reg == 5'h13) || (cnt_reg < 5'h09);
      if (cnt_reg == 5'h09) begin
        tx_word <= word_in;
      end
    end
  end
  // receive word taken at the rise of the recovered clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_prev_reg <= 1'b0;
      got         <= '0;
    end else begin
      rx_prev_reg <= rx_word_clock;
      if (rx_word_clock && !rx_prev_reg) begin
        got <= {rx_data, rx_kcode_high_flag, rx_kcode_low_flag};
      end
    end
  end
endmodule : sdp_partner

// file: testbench/sdp_top_chk.sv
// concurrent checks on the ports of the serdes parallel word block
`timescale 1ns/1ns
module sdp_top_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        tx_bit_clock,
  input wire logic        signal_absent,
  input wire logic        pattern_test_enable,
  input wire logic        rx_word_clock,
  input wire logic [15:0] rx_data,
  input wire logic        rx_kcode_low_flag,
  input wire logic        rx_kcode_high_flag,
  input wire logic        pattern_check_ok
);
  logic [4:0] los_cnt_reg;
  logic [4:0] los_cnt_next;
  //////////////////////////////////////////////////////////////////////
  // saturating count of cycles with the line absent
  always_comb begin
    los_cnt_next = !signal_absent ? 5'h00 :
      (los_cnt_reg == 5'h1F) ? los_cnt_reg : los_cnt_reg + 5'h01;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      los_cnt_reg <= 5'h00;
    end else begin
      los_cnt_reg <= los_cnt_next;
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_bit_clk;
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) |-> tx_bit_clock != $past(tx_bit_clock);
  endproperty
  a_bit_clk: assert property (p_bit_clk)
    else $error("bit clock missed a toggle");
  // a realign restarts the count, so a high phase can only grow
  property p_rx_clk_high;
    @(posedge clk) disable iff (!reset_n)
    $rose(rx_word_clock) |-> rx_word_clock [*8];
  endproperty
  a_rx_clk_high: assert property (p_rx_clk_high)
    else $error("recovered clock high phase too short");
  // reset is the cause here, so it cannot also disable the check
  property p_rx_clk_rst;
    @(posedge clk) !reset_n |-> !rx_word_clock;
  endproperty
  a_rx_clk_rst: assert property (p_rx_clk_rst)
    else $error("recovered clock not low in reset");
  property p_data_sync;
    @(posedge clk) disable iff (!reset_n)
    !$stable(rx_data) |-> $fell(rx_word_clock);
  endproperty
  a_data_sync: assert property (p_data_sync)
    else $error("receive word moved off the clock fall");
  property p_khi_sync;
    @(posedge clk) disable iff (!reset_n)
    !$stable(rx_kcode_high_flag) |-> $fell(rx_word_clock);
  endproperty
  a_khi_sync: assert property (p_khi_sync)
    else $error("high flag moved off the clock fall");
  property p_klo_sync;
    @(posedge clk) disable iff (!reset_n)
    !pattern_test_enable && !$past(pattern_test_enable) &&
      !$past(pattern_test_enable, 2) &&
      !$stable(rx_kcode_low_flag) |-> $fell(rx_word_clock);
  endproperty
  a_klo_sync: assert property (p_klo_sync)
    else $error("low flag moved off the clock fall");
  property p_pat_flag;
    @(posedge clk) disable iff (!reset_n)
    pattern_test_enable && $past(pattern_test_enable) |->
      rx_kcode_low_flag == $past(pattern_check_ok);
  endproperty
  a_pat_flag: assert property (p_pat_flag)
    else $error("low flag does not follow pattern result");
  property p_los;
    @(posedge clk) disable iff (!reset_n)
    los_cnt_reg > 5'h15 && $fell(rx_word_clock) && !pattern_test_enable
      |-> rx_data == 16'hFFFF && rx_kcode_low_flag && rx_kcode_high_flag;
  endproperty
  a_los: assert property (p_los)
    else $error("lost line not shown as K31.7");
  property p_bus_wait;
    @(posedge clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus held more than one wait cycle");
endmodule : sdp_top_chk
bind sdp_top sdp_top_chk u_chk (.clk, .reset_n, .avs_read, .avs_write,
  .avs_waitrequest, .tx_bit_clock, .signal_absent, .pattern_test_enable,
  .rx_word_clock, .rx_data, .rx_kcode_low_flag, .rx_kcode_high_flag,
  .pattern_check_ok);

// file: testbench/test_sdp_top.sv
// self-checking bench: transmit timing, loopback decode, flags, irq
`timescale 1ns/1ns
module test_sdp_top;
  import sdp_pkg::*;
  logic         clk = 1'b0, reset_n = 1'b0;
  logic [4:0]   avs_address = 5'h00;
  logic         avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0, avs_readdata, q;
  logic         avs_waitrequest, irq, ref_clk, tx_serial, tx_bit_clock;
  logic         signal_absent = 1'b0, pattern_test_enable = 1'b0;
  logic         force_one = 1'b0, flip = 1'b0;
  logic         rx_word_clock, kl, kh, pattern_check_ok;
  logic [15:0]  rx_data;
  logic [17:0]  got;
  sdp_tx_word_t tx_word, p_word = '0;
  int           miscompares = 0, n_checks = 0, cyc = 0;
  // loopback with an all-ones override and a one-bit corruption
  wire rx_serial = force_one | (tx_serial ^ flip);
  localparam logic [17:0] RXW [4] = '{{16'hB5BC, 2'b01},
    {16'hF7BC, 2'b11}, {16'hB5B5, 2'b00}, {16'hF7B5, 2'b10}};
  sdp_top dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
    .reference_word_clock(ref_clk), .tx_word, .tx_serial, .tx_bit_clock,
    .rx_serial, .signal_absent, .pattern_test_enable,
    .factory_test_enable(1'b0),
    .rx_word_clock, .rx_data, .rx_kcode_low_flag(kl),
    .rx_kcode_high_flag(kh), .pattern_check_ok);
  sdp_partner u_far (.clk, .reset_n, .word_in(p_word),
    .reference_word_clock(ref_clk), .tx_word, .rx_word_clock, .rx_data,
    .rx_kcode_low_flag(kl), .rx_kcode_high_flag(kh), .got);
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // one bus cycle; an edge first so strobes are never set twice at once
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // a hang costs a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (12) @(posedge clk);
    chk("rx_clk_rst", 32'(rx_word_clock), 32'h0);
    chk("rx_data_rst", 32'(rx_data), 32'h0);
    reset_n <= 1'b1;
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    bus(1'b0, 5'h00, 32'h0);
    chk("ctrl_rst", q, 32'h1);
    bus(1'b1, 5'h0C, 32'hF);
    bus(1'b0, 5'h0C, 32'h0);
    chk("mask_rw", q, 32'hF);
    bus(1'b1, 5'h0C, 32'h0);
    bus(1'b1, 5'h14, 32'hFFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // the low comma flips disparity every word, the high byte must not
  task automatic t_tx();
    logic [39:0] w;
    p_word <= '{data: 16'hB5BC, k_hi: 1'b0, k_lo: 1'b1};
    repeat (60) @(posedge clk);
    @(posedge ref_clk);
    @(posedge clk);
    repeat (36) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1 w[i] = tx_serial;
    end
    chk("tx_lo", 32'(w[9:0] == 10'h17C || w[9:0] == 10'h283), 32'h1);
    chk("tx_hi", 32'(w[19:10]), 32'h155);
    chk("tx_lo2", 32'(w[29:20] ^ w[9:0]), 32'h3FF);
    chk("tx_hi2", 32'(w[39:30]), 32'h155);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      p_word <= RXW[i];
      repeat (200) @(posedge clk);
      chk("rx_word", 32'(got), 32'(RXW[i]));
      bus(1'b0, 5'h10, 32'h0);
      chk("rx_reg", q, 32'({RXW[i][1:0], RXW[i][17:2]}));
    end
    $display("test rx done");
  endtask : t_rx
  task automatic t_pat();
    pattern_test_enable <= 1'b1;
    repeat (300) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    repeat (40) @(posedge clk);
    chk("pat_ok", 32'(pattern_check_ok), 32'h1);
    chk("pat_pin", 32'(kl), 32'h1);
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    repeat (60) @(posedge clk);
    chk("irq_masked", 32'(irq), 32'h0);
    bus(1'b1, 5'h0C, 32'h8);
    #1 chk("irq_on", 32'(irq), 32'h1);
    bus(1'b0, 5'h08, 32'h0);
    chk("irq_stat", 32'(q[3]), 32'h1);
    #1 chk("irq_clear", 32'(irq), 32'h0);
    bus(1'b1, 5'h0C, 32'h0);
    pattern_test_enable <= 1'b0;
    repeat (300) @(posedge clk);
    $display("test pattern done");
  endtask : t_pat
  task automatic t_los();
    signal_absent <= 1'b1;
    repeat (100) @(posedge clk);
    chk("los_word", 32'(got), 32'h3FFFF);
    bus(1'b0, 5'h04, 32'h0);
    chk("los_stat", 32'(q[1]), 32'h1);
    signal_absent <= 1'b0;
    repeat (200) @(posedge clk);
    $display("test los done");
  endtask : t_los
  task automatic t_err();
    force_one <= 1'b1;
    repeat (100) @(posedge clk);
    chk("err_word", 32'(got), 32'h3);
    force_one <= 1'b0;
    repeat (200) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk("err_stat", 32'(q[0]), 32'h1);
    $display("test error done");
  endtask : t_err
  initial begin
    t_reset();
    t_regs();
    t_tx();
    t_rx();
    t_pat();
    t_los();
    t_err();
    wrap_up();
  end
endmodule : test_sdp_top
